// *** fswc_top.sv ***
`timescale 1ns/1ps
module fswc_top #(
   parameter logic [15:0] FLASH_END_ADDR = 16'hEFFF,
   parameter logic [7:0] FLASH_BLOCKS = 8'h01,
   parameter logic [7:0] FLASH_AREAS = 8'h01
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic VPP_SENSE,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic CALL_REQ,
   input wire logic [7:0] CALL_FUNC,
   input wire logic [15:0] CALL_HL,
   output logic CALL_BUSY,
   output logic CALL_DONE,
   output logic [7:0] CALL_STATUS,
   output logic [15:0] RAM_ADDR,
   output logic RAM_RD,
   input wire logic [7:0] RAM_RDATA,
   output logic RAM_WR,
   output logic [7:0] RAM_WDATA,
   output logic [15:0] FL_ADDR,
   output logic FL_RD,
   input wire logic [7:0] FL_RDATA,
   output logic FL_WR,
   output logic [7:0] FL_WDATA
);

   typedef struct packed {
      fswc_pkg::fswc_state_t st;
      logic mode_sel;
      logic [7:0] rdata;
      logic [7:0] func;
      logic [15:0] hl;
      logic [2:0] ph;
      logic [7:0] idx;
      logic [15:0] addr;
      logic [15:0] sa;
      logic [15:0] ea;
      logic [7:0] cnt;
      logic [7:0] wtime;
      logic [23:0] etime;
      logic [15:0] bufp;
      logic pvalid;
      logic [7:0] dat;
      logic [7:0] status;
      logic busy;
      logic done;
      logic [15:0] ram_addr;
      logic ram_rd;
      logic ram_wr;
      logic [7:0] ram_wdata;
      logic [15:0] fl_addr;
      logic fl_rd;
      logic fl_wr;
      logic [7:0] fl_wdata;
   } fswc_regs_t;

   fswc_regs_t q;
   fswc_regs_t n;
   logic vpp;

   ////////////////////////////////////////////////////////////////
   // supply sense pin comes from outside the clock domain
   fswc_sync3 u_sense (
      .CLK(CLK),
      .RSTN(RSTN),
      .din(VPP_SENSE),
      .dout(vpp)
   );

   ////////////////////////////////////////////////////////////////
   function automatic logic [15:0] offs(input logic [15:0] base, input logic [7:0] ofs);
      offs = base + {8'h00, ofs};
   endfunction

   function automatic logic wt_ok(input logic [7:0] wt);
      wt_ok = (wt == fswc_pkg::WT_BAND0) || (wt == fswc_pkg::WT_BAND1) ||
              (wt == fswc_pkg::WT_BAND2) || (wt == fswc_pkg::WT_BAND3);
   endfunction

   // information read places end address, block and area totals
   function automatic logic [7:0] info_ofs(input logic [7:0] i);
      case (i)
         8'h00: info_ofs = fswc_pkg::OFS_END_LO;
         8'h01: info_ofs = fswc_pkg::OFS_END_HI;
         8'h02: info_ofs = fswc_pkg::OFS_BLOCKS;
         default: info_ofs = fswc_pkg::OFS_AREAS;
      endcase
   endfunction

   function automatic logic [7:0] info_byte(input logic [7:0] i);
      case (i)
         8'h00: info_byte = FLASH_END_ADDR[7:0];
         8'h01: info_byte = FLASH_END_ADDR[15:8];
         8'h02: info_byte = FLASH_BLOCKS;
         default: info_byte = FLASH_AREAS;
      endcase
   endfunction

   // parameter fields fetched by set-params, in load order
   function automatic logic [7:0] load_ofs(input logic [7:0] i);
      case (i)
         8'h00: load_ofs = fswc_pkg::OFS_START_LO;
         8'h01: load_ofs = fswc_pkg::OFS_START_HI;
         8'h02: load_ofs = fswc_pkg::OFS_END_LO;
         8'h03: load_ofs = fswc_pkg::OFS_END_HI;
         8'h04: load_ofs = fswc_pkg::OFS_COUNT;
         8'h05: load_ofs = fswc_pkg::OFS_WTIME;
         8'h06: load_ofs = fswc_pkg::OFS_ETIME_0;
         8'h07: load_ofs = fswc_pkg::OFS_ETIME_1;
         8'h08: load_ofs = fswc_pkg::OFS_ETIME_2;
         8'h09: load_ofs = fswc_pkg::OFS_BUF_LO;
         default: load_ofs = fswc_pkg::OFS_BUF_HI;
      endcase
   endfunction

   function automatic logic writes_flash(input logic [7:0] f);
      writes_flash = (f == fswc_pkg::FN_PREWRITE) || (f == fswc_pkg::FN_ERASE);
   endfunction

   function automatic logic [7:0] fill_byte(input logic [7:0] f);
      fill_byte = (f == fswc_pkg::FN_PREWRITE) ? fswc_pkg::FL_PREWRITTEN : fswc_pkg::FL_ERASED;
   endfunction

   // area result flags
   // erase that leaves a non-blank byte reports as a blank check failure
   function automatic logic [7:0] area_err(input logic [7:0] f, input logic [7:0] d);
      area_err = 8'h00;
      if (((f == fswc_pkg::FN_BLANK) || (f == fswc_pkg::FN_ERASE)) && (d != fswc_pkg::FL_ERASED)) begin
         area_err[fswc_pkg::ST_BLANK_BIT] = 1'b1;
      end
      if ((f == fswc_pkg::FN_PREWRITE) && (d != fswc_pkg::FL_PREWRITTEN)) begin
         area_err[fswc_pkg::ST_WRITE_BIT] = 1'b1;
      end
   endfunction

   // supply gate
   // a low sense bit means no erase/write voltage, so a write, prewrite or erase call is refused
   function automatic logic [7:0] refuse(input logic pv, input logic range_ok, input logic supply_ok);
      refuse = 8'h00;
      if (!pv || !range_ok) begin
         refuse[fswc_pkg::ST_PARAM_BIT] = 1'b1;
      end else if (!supply_ok) begin
         refuse[fswc_pkg::ST_WRITE_BIT] = 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   always_comb begin
      n = q;
      n.ram_rd = 1'b0;
      n.ram_wr = 1'b0;
      n.fl_rd = 1'b0;
      n.fl_wr = 1'b0;
      n.done = 1'b0;
      // only the select bit is stored; other written bits are dropped
      if (REG_WR && (REG_ADDR == fswc_pkg::MODE_ADDR)) begin
         n.mode_sel = REG_WDATA[fswc_pkg::MODE_SEL_BIT];
      end
      // sense bit view
      // fixed bits always read as the only legal pattern
      n.rdata = fswc_pkg::REG_UNMAPPED;
      if (REG_ADDR == fswc_pkg::MODE_ADDR) begin
         n.rdata = fswc_pkg::MODE_FIXED;
         n.rdata[fswc_pkg::MODE_SEL_BIT] = q.mode_sel;
         n.rdata[fswc_pkg::MODE_SENSE_BIT] = vpp;
      end
      case (q.st)
         fswc_pkg::ST_IDLE: begin
            if (CALL_REQ) begin
               n.func = CALL_FUNC;
               n.hl = CALL_HL;
               n.busy = 1'b1;
               n.status = 8'h00;
               n.idx = 8'h00;
               n.addr = q.sa;
               n.ph = fswc_pkg::PH_ISSUE;
               n.st = fswc_pkg::ST_DONE;
               // normal mode refuses
               // a call outside self-write mode ends at once, flash untouched
               if (!q.mode_sel) begin
                  n.status[fswc_pkg::ST_PARAM_BIT] = 1'b1;
               end else begin
                  case (CALL_FUNC)
                     fswc_pkg::FN_INIT: begin
                        n.pvalid = 1'b0;
                     end
                     fswc_pkg::FN_SETENV: begin
                        n.st = fswc_pkg::ST_LOAD;
                     end
                     fswc_pkg::FN_INFO: begin
                        n.st = fswc_pkg::ST_INFO;
                     end
                     fswc_pkg::FN_WRITE: begin
                        n.status = refuse(q.pvalid, 1'b1, vpp);
                        if (n.status == 8'h00) begin
                           n.st = fswc_pkg::ST_WRITE;
                        end
                     end
                     fswc_pkg::FN_BLANK, fswc_pkg::FN_PREWRITE, fswc_pkg::FN_ERASE, fswc_pkg::FN_VERIFY: begin
                        n.status = refuse(q.pvalid, q.ea >= q.sa, vpp || !writes_flash(CALL_FUNC));
                        if (n.status == 8'h00) begin
                           n.st = fswc_pkg::ST_AREA;
                        end
                     end
                     default: begin
                        n.status[fswc_pkg::ST_PARAM_BIT] = 1'b1;
                     end
                  endcase
               end
            end
         end
         fswc_pkg::ST_LOAD: begin
            case (q.ph)
               fswc_pkg::PH_ISSUE: begin
                  n.ram_addr = offs(q.hl, load_ofs(q.idx));
                  n.ram_rd = 1'b1;
                  n.ph = fswc_pkg::PH_WAIT;
               end
               fswc_pkg::PH_WAIT: begin
                  case (q.idx)
                     8'h00: n.sa[7:0] = RAM_RDATA;
                     8'h01: n.sa[15:8] = RAM_RDATA;
                     8'h02: n.ea[7:0] = RAM_RDATA;
                     8'h03: n.ea[15:8] = RAM_RDATA;
                     8'h04: n.cnt = RAM_RDATA;
                     8'h05: n.wtime = RAM_RDATA;
                     8'h06: n.etime[7:0] = RAM_RDATA;
                     8'h07: n.etime[15:8] = RAM_RDATA;
                     8'h08: n.etime[23:16] = RAM_RDATA;
                     8'h09: n.bufp[7:0] = RAM_RDATA;
                     default: n.bufp[15:8] = RAM_RDATA;
                  endcase
                  n.ph = fswc_pkg::PH_CHECK;
               end
               default: begin
                  n.ph = fswc_pkg::PH_ISSUE;
                  n.idx = q.idx + 8'h01;
                  // a bad write-time code or zero erase time blocks later write and area calls
                  if (load_ofs(q.idx) == fswc_pkg::OFS_BUF_HI) begin
                     n.pvalid = wt_ok(q.wtime) && (q.etime != 24'h000000);
                     n.status[fswc_pkg::ST_PARAM_BIT] = !n.pvalid;
                     n.st = fswc_pkg::ST_DONE;
                  end
               end
            endcase
         end
         fswc_pkg::ST_INFO: begin
            if (q.ph == fswc_pkg::PH_ISSUE) begin
               n.ram_addr = offs(q.hl, info_ofs(q.idx));
               n.ram_wdata = info_byte(q.idx);
               n.ram_wr = 1'b1;
               n.ph = fswc_pkg::PH_CHECK;
            end else begin
               n.ph = fswc_pkg::PH_ISSUE;
               n.idx = q.idx + 8'h01;
               if (q.idx == fswc_pkg::INFO_LAST) begin
                  n.st = fswc_pkg::ST_DONE;
               end
            end
         end
         fswc_pkg::ST_WRITE: begin
            case (q.ph)
               fswc_pkg::PH_ISSUE: begin
                  n.ram_addr = offs(q.bufp, q.idx);
                  n.ram_rd = 1'b1;
                  n.ph = fswc_pkg::PH_WAIT;
               end
               fswc_pkg::PH_WAIT: begin
                  n.dat = RAM_RDATA;
                  n.ph = fswc_pkg::PH_DATA;
               end
               fswc_pkg::PH_DATA: begin
                  n.fl_addr = offs(q.sa, q.idx);
                  n.fl_wdata = q.dat;
                  n.fl_wr = q.mode_sel;
                  n.ph = fswc_pkg::PH_RBACK;
               end
               fswc_pkg::PH_RBACK: begin
                  n.fl_rd = 1'b1;
                  n.ph = fswc_pkg::PH_RWAIT;
               end
               fswc_pkg::PH_RWAIT: begin
                  if (FL_RDATA != q.dat) begin
                     n.status[fswc_pkg::ST_WRITE_BIT] = 1'b1;
                  end
                  n.ph = fswc_pkg::PH_CHECK;
               end
               default: begin
                  n.ph = fswc_pkg::PH_ISSUE;
                  n.idx = q.idx + 8'h01;
                  // count of 1 to 256
                  // a count of zero wraps round to a full 256-byte buffer
                  if (q.idx == (q.cnt - 8'h01)) begin
                     n.st = fswc_pkg::ST_DONE;
                  end
               end
            endcase
         end
         fswc_pkg::ST_AREA: begin
            case (q.ph)
               fswc_pkg::PH_ISSUE: begin
                  n.fl_addr = q.addr;
                  n.fl_wdata = fill_byte(q.func);
                  n.fl_wr = q.mode_sel && writes_flash(q.func);
                  n.ph = fswc_pkg::PH_RBACK;
               end
               fswc_pkg::PH_RBACK: begin
                  n.fl_rd = 1'b1;
                  n.ph = fswc_pkg::PH_RWAIT;
               end
               fswc_pkg::PH_RWAIT: begin
                  n.dat = FL_RDATA;
                  n.ph = (q.func == fswc_pkg::FN_VERIFY) ? fswc_pkg::PH_WAIT : fswc_pkg::PH_CHECK;
               end
               fswc_pkg::PH_WAIT: begin
                  n.fl_rd = 1'b1;
                  n.ph = fswc_pkg::PH_DATA;
               end
               fswc_pkg::PH_DATA: begin
                  // verify reads each byte twice; a byte that drifts fails
                  if (FL_RDATA != q.dat) begin
                     n.status[fswc_pkg::ST_VERIFY_BIT] = 1'b1;
                  end
                  n.ph = fswc_pkg::PH_CHECK;
               end
               default: begin
                  n.status = q.status | area_err(q.func, q.dat);
                  n.ph = fswc_pkg::PH_ISSUE;
                  n.addr = q.addr + 16'h0001;
                  if (q.addr == q.ea) begin
                     n.st = fswc_pkg::ST_DONE;
                  end
               end
            endcase
         end
         fswc_pkg::ST_DONE: begin
            n.done = 1'b1;
            n.busy = 1'b0;
            n.st = fswc_pkg::ST_IDLE;
         end
         default: begin
            n.st = fswc_pkg::ST_IDLE;
         end
      endcase
   end

   // reset state
   // all-zero state is idle and normal mode; the register reads 08H
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign REG_RDATA = q.rdata;
   assign CALL_BUSY = q.busy;
   assign CALL_DONE = q.done;
   assign CALL_STATUS = q.status;
   assign RAM_ADDR = q.ram_addr;
   assign RAM_RD = q.ram_rd;
   assign RAM_WR = q.ram_wr;
   assign RAM_WDATA = q.ram_wdata;
   assign FL_ADDR = q.fl_addr;
   assign FL_RD = q.fl_rd;
   assign FL_WR = q.fl_wr;
   assign FL_WDATA = q.fl_wdata;

endmodule

// *** fswc_pkg.sv ***
package fswc_pkg;

   // mode control register, reached at its own memory address
   localparam logic [15:0] MODE_ADDR = 16'hFFCD;
   localparam logic [7:0] MODE_RESET = 8'h08;
   localparam logic [7:0] MODE_FIXED = 8'h08;
   localparam int MODE_SEL_BIT = 0;
   localparam int MODE_SENSE_BIT = 2;
   localparam logic [7:0] REG_UNMAPPED = 8'h00;

   // function numbers carried in the C register
   localparam logic [7:0] FN_INIT = 8'h00;
   localparam logic [7:0] FN_SETENV = 8'h01;
   localparam logic [7:0] FN_INFO = 8'h02;
   localparam logic [7:0] FN_BLANK = 8'h10;
   localparam logic [7:0] FN_PREWRITE = 8'h20;
   localparam logic [7:0] FN_ERASE = 8'h30;
   localparam logic [7:0] FN_WRITE = 8'h50;
   localparam logic [7:0] FN_VERIFY = 8'h60;

   // result byte returned in the B register
   localparam int ST_PARAM_BIT = 7;
   localparam int ST_VERIFY_BIT = 4;
   localparam int ST_WRITE_BIT = 3;
   localparam int ST_BLANK_BIT = 1;

   // parameter block byte offsets from HL
   localparam logic [7:0] OFS_START_LO = 8'h02;
   localparam logic [7:0] OFS_START_HI = 8'h03;
   localparam logic [7:0] OFS_END_LO = 8'h04;
   localparam logic [7:0] OFS_END_HI = 8'h05;
   localparam logic [7:0] OFS_COUNT = 8'h06;
   localparam logic [7:0] OFS_WTIME = 8'h07;
   localparam logic [7:0] OFS_ETIME_0 = 8'h08;
   localparam logic [7:0] OFS_ETIME_1 = 8'h09;
   localparam logic [7:0] OFS_ETIME_2 = 8'h0A;
   localparam logic [7:0] OFS_BUF_LO = 8'h0E;
   localparam logic [7:0] OFS_BUF_HI = 8'h0F;
   localparam logic [7:0] OFS_BLOCKS = 8'h10;
   localparam logic [7:0] OFS_AREAS = 8'h11;
   localparam logic [7:0] INFO_LAST = 8'h03;

   // accepted write-time codes per oscillator band
   localparam logic [7:0] WT_BAND0 = 8'h20;
   localparam logic [7:0] WT_BAND1 = 8'h40;
   localparam logic [7:0] WT_BAND2 = 8'h60;
   localparam logic [7:0] WT_BAND3 = 8'h80;

   // flash byte values
   localparam logic [7:0] FL_ERASED = 8'hFF;
   localparam logic [7:0] FL_PREWRITTEN = 8'h00;

   // memory access phases
   localparam logic [2:0] PH_ISSUE = 3'h0;
   localparam logic [2:0] PH_WAIT = 3'h1;
   localparam logic [2:0] PH_DATA = 3'h2;
   localparam logic [2:0] PH_RBACK = 3'h3;
   localparam logic [2:0] PH_RWAIT = 3'h4;
   localparam logic [2:0] PH_CHECK = 3'h5;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_INFO,
      ST_AREA,
      ST_WRITE,
      ST_DONE
   } fswc_state_t;

endpackage

// *** fswc_sync3.sv ***
`timescale 1ns/1ps
module fswc_sync3 (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic din,
   output logic dout
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } fswc_sync_t;

   fswc_sync_t q;
   fswc_sync_t n;

   ////////////////////////////////////////////////////////////////
   // three stages; level moves only once stages two and three agree
   always_comb begin
      n = q;
      n.s1 = din;
      n.s2 = q.s1;
      n.s3 = q.s2;
      if (q.s2 == q.s3) begin
         n.lvl = q.s3;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign dout = q.lvl;

endmodule

// *** fswc_chk.sv ***
`timescale 1ns/1ps
module fswc_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic VPP_SENSE,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic CALL_BUSY,
   input wire logic CALL_DONE,
   input wire logic [7:0] CALL_STATUS,
   input wire logic RAM_RD,
   input wire logic RAM_WR,
   input wire logic FL_RD,
   input wire logic FL_WR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic sel_q;
   // select bit as last written, so normal mode can be watched
   always_ff @(posedge CLK) begin
      if (!RSTN) sel_q <= 1'b0;
      else if (REG_WR && REG_ADDR == fswc_pkg::MODE_ADDR) sel_q <= REG_WDATA[0];
   end
   // address held one edge covers a registered read path
   sequence rd_s; REG_ADDR == fswc_pkg::MODE_ADDR && $stable(REG_ADDR) && $past(RSTN); endsequence
   a_fixed_bits: assert property (rd_s |-> (REG_RDATA & 8'hFA) == 8'h08)
      else $error("mode fixed bits wrong");
   // six stable edges leave room for the three-stage sense synchroniser
   a_sense_high: assert property (VPP_SENSE [*6] ##0 rd_s |-> REG_RDATA[2])
      else $error("sense bit not set");
   a_sense_low: assert property (!VPP_SENSE [*6] ##0 rd_s |-> !REG_RDATA[2])
      else $error("sense bit not clear");
   a_status_unused: assert property (CALL_DONE |-> (CALL_STATUS & 8'h65) == 8'h00)
      else $error("unused status bits set");
   a_normal_no_flash: assert property (!sel_q && !$past(sel_q) |-> !FL_WR)
      else $error("flash written in normal mode");
   a_flash_in_call: assert property (FL_WR |-> CALL_BUSY)
      else $error("flash written outside a call");
   a_ram_one_op: assert property (!(RAM_RD && RAM_WR))
      else $error("ram read and write together");
   a_flash_one_op: assert property (!(FL_RD && FL_WR))
      else $error("flash read and write together");
   c_error_status: cover property (CALL_DONE && CALL_STATUS[7]);
   c_flash_write: cover property (FL_WR);
   c_sense_seen: cover property (VPP_SENSE [*6] ##0 rd_s ##0 REG_RDATA[2]);
endmodule

// *** fswc_mem_model.sv ***
`timescale 1ns/1ps
module fswc_mem_model (
   input wire logic CLK,
   input wire logic [15:0] RAM_ADDR,
   input wire logic RAM_WR,
   input wire logic [7:0] RAM_WDATA,
   output logic [7:0] RAM_RDATA,
   input wire logic [15:0] FL_ADDR,
   input wire logic FL_WR,
   input wire logic [7:0] FL_WDATA,
   output logic [7:0] FL_RDATA
);
   logic [7:0] ram [0:65535];
   logic [7:0] fl [0:65535];
   int fl_writes = 0;
   assign RAM_RDATA = ram[RAM_ADDR];
   assign FL_RDATA = fl[FL_ADDR];
   initial foreach (fl[i]) fl[i] = fswc_pkg::FL_ERASED;
   // writes land on the edge; count flash writes for the mode check
   always @(posedge CLK) begin
      if (RAM_WR) ram[RAM_ADDR] <= RAM_WDATA;
      if (FL_WR) fl[FL_ADDR] <= FL_WDATA;
      if (FL_WR) fl_writes++;
   end
endmodule

// *** tb_flash_self_write_control.sv ***
`timescale 1ns/1ps
bind fswc_top fswc_chk chk_u (.*);
////////////////////////////////////////
module tb_flash_self_write_control;
   localparam logic [15:0] M = fswc_pkg::MODE_ADDR;
   logic CLK = 0, RSTN = 0, VPP_SENSE = 0, REG_WR = 0, CALL_REQ = 0, done_q = 0;
   logic CALL_BUSY, CALL_DONE, RAM_RD, RAM_WR, FL_RD, FL_WR;
   logic [15:0] REG_ADDR = 0, CALL_HL = 16'hFD00, RAM_ADDR, FL_ADDR;
   logic [7:0] REG_WDATA = 0, CALL_FUNC = 0, REG_RDATA, CALL_STATUS, RAM_RDATA, RAM_WDATA, FL_RDATA, FL_WDATA;
   logic [7:0] exp_q[$], bb[8];
   int n_fail = 0, check_count = 0, n;
   fswc_top dut_u (.*);
   fswc_mem_model mem_u (.*);
   task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(posedge CLK) REG_ADDR <= a;
      // room for the three-stage sense path plus the registered read
      repeat (6) @(posedge CLK);
      cmp("reg", e, REG_RDATA);
   endtask
   task automatic wr(logic [7:0] d);
      @(posedge CLK) begin
         REG_ADDR <= M;
         REG_WDATA <= d;
         REG_WR <= 1'b1;
      end
      @(posedge CLK) REG_WR <= 1'b0;
   endtask
   // request held until the block shows it has taken it
   task automatic call(logic [7:0] f, logic [7:0] st, bit chk);
      int t = 0;
      if (chk) exp_q.push_back(st);
      @(posedge CLK) begin
         CALL_REQ <= 1'b1;
         CALL_FUNC <= f;
      end
      do @(posedge CLK); while (!CALL_BUSY && !CALL_DONE && ++t < 40);
      CALL_REQ <= 1'b0;
      while (CALL_BUSY && ++t < 9000) @(posedge CLK);
      repeat (4) @(posedge CLK);
   endtask
   // block reserved in RAM at HL; the stack is never touched here
   task automatic pb(logic [7:0] o, logic [7:0] v);
      mem_u.ram[CALL_HL + 16'(o)] = v;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial forever #50 CLK = ~CLK;
   // each rising done takes the oldest expected status
   always @(posedge CLK) begin
      done_q <= CALL_DONE;
      if (CALL_DONE && !done_q && exp_q.size() > 0) cmp("status", exp_q.pop_front(), CALL_STATUS);
   end
   initial begin
      void'($urandom(32'h8bd9));
      repeat (4) @(posedge CLK);
      RSTN <= 1'b1;
      rd(M, fswc_pkg::MODE_RESET);
      rd(16'h0000, fswc_pkg::REG_UNMAPPED);
      wr(8'h0C);
      rd(M, 8'h08);
      call(fswc_pkg::FN_ERASE, 8'h80, 1);
      cmp("flash writes", 8'h00, 8'(mem_u.fl_writes));
      VPP_SENSE <= 1'b1;
      rd(M, 8'h0C);
      wr(8'h09);
      rd(M, 8'h0D);
      n = $urandom_range(8, 1);
      for (int i = 0; i < n; i++) bb[i] = 8'($urandom);
      for (int i = 0; i < n; i++) mem_u.ram[16'hFE00 + i] = bb[i];
      pb(fswc_pkg::OFS_START_LO, 8'h00);
      pb(fswc_pkg::OFS_START_HI, 8'h10);
      pb(fswc_pkg::OFS_END_LO, 8'h00);
      pb(fswc_pkg::OFS_COUNT, 8'(n));
      pb(fswc_pkg::OFS_WTIME, fswc_pkg::WT_BAND3);
      pb(fswc_pkg::OFS_ETIME_0, 8'h01);
      pb(fswc_pkg::OFS_ETIME_1, 8'h40);
      pb(fswc_pkg::OFS_ETIME_2, 8'h00);
      pb(fswc_pkg::OFS_BUF_LO, 8'h00);
      pb(fswc_pkg::OFS_BUF_HI, 8'hFE);
      call(fswc_pkg::FN_INIT, 8'h00, 1);
      call(fswc_pkg::FN_SETENV, 8'h00, 1);
      call(fswc_pkg::FN_INFO, 8'h00, 1);
      cmp("end lo", 8'hFF, mem_u.ram[16'hFD04]);
      cmp("blocks", 8'h01, mem_u.ram[16'hFD10]);
      cmp("areas", 8'h01, mem_u.ram[16'hFD11]);
      call(fswc_pkg::FN_WRITE, 8'h00, 1);
      for (int i = 0; i < n; i++) cmp("flash", bb[i], mem_u.fl[16'h1000 + i]);
      cmp("past end", fswc_pkg::FL_ERASED, mem_u.fl[16'h1000 + n]);
      pb(fswc_pkg::OFS_WTIME, 8'h33);
      call(fswc_pkg::FN_SETENV, 8'h80, 1);
      pb(fswc_pkg::OFS_WTIME, fswc_pkg::WT_BAND3);
      pb(fswc_pkg::OFS_START_HI, 8'h20);
      pb(fswc_pkg::OFS_END_LO, 8'h03);
      pb(fswc_pkg::OFS_END_HI, 8'h20);
      call(fswc_pkg::FN_SETENV, 8'h00, 1);
      call(fswc_pkg::FN_BLANK, 8'h00, 1);
      call(fswc_pkg::FN_PREWRITE, 8'h00, 1);
      cmp("prewritten", fswc_pkg::FL_PREWRITTEN, mem_u.fl[16'h2003]);
      call(fswc_pkg::FN_BLANK, 8'h02, 1);
      call(fswc_pkg::FN_ERASE, 8'h00, 1);
      cmp("erased", fswc_pkg::FL_ERASED, mem_u.fl[16'h2000]);
      call(fswc_pkg::FN_VERIFY, 8'h00, 1);
      VPP_SENSE <= 1'b0;
      rd(M, 8'h09);
      call(fswc_pkg::FN_WRITE, 8'h08, 1);
      wr(8'h08);
      rd(M, 8'h08);
      cmp("pending", 8'h00, 8'(exp_q.size()));
      tally_and_finish;
   end
   // guard against a hang: 30000 cycles
   initial begin
      #3000000;
      n_fail++;
      tally_and_finish;
   end
endmodule
